/* File: rtl/dlic_consts.svh */
// constants for the dual level interrupt controller: offsets, fields, resets
// assumes inclusion by bare name from rtl and tb files; holds definitions only
`ifndef DLIC_CONSTS_SVH
`define DLIC_CONSTS_SVH

// register byte addresses on the avalon slave
`define DLIC_ADDR_W 6
`define DLIC_OFF_NORM_RAW 6'h00
`define DLIC_OFF_NORM_MASK 6'h04
`define DLIC_OFF_NORM_CLR 6'h08
`define DLIC_OFF_NORM_PEND 6'h0C
`define DLIC_OFF_FAST_RAW 6'h10
`define DLIC_OFF_FAST_MASK 6'h14
`define DLIC_OFF_FAST_CLR 6'h18
`define DLIC_OFF_FAST_PEND 6'h1C
`define DLIC_OFF_SOFT_INTERRUPT_CONFIG 6'h20

// bit positions common to every level register
`define DLIC_BIT_SUM 0
`define DLIC_BIT_SWI 1
`define DLIC_SRC_LO 2
`define DLIC_SRC_HI 11
`define DLIC_NUM_SRC 10

// maskable source bits; sum, software and reserved bits ignore mask writes
`define DLIC_SRC_MASK 32'h00000FFC

// soft interrupt config fields
`define DLIC_SOFT_INTERRUPT_CONFIG_NORM 1
`define DLIC_SOFT_INTERRUPT_CONFIG_FAST 2
`define DLIC_SOFT_INTERRUPT_CONFIG_MASK 32'h00000006

// reset values
`define DLIC_MASK_RST 32'h00000000
`define DLIC_SOFT_INTERRUPT_CONFIG_RST 32'h00000000
`define DLIC_WORD_ZERO 32'h00000000

`endif

/* File: rtl/dlic_pkg.sv */
// types for the dual level interrupt controller
// assumes nothing of its surroundings; constants live in dlic_consts.svh
package dlic_pkg;

    // avalon slave handshake states
    typedef enum logic {
        dlic_bus_idle,
        dlic_bus_ack
    } dlic_bus_state_t;

    typedef logic [31:0] dlic_word_t;

endpackage

/* File: rtl/dlic_avmm_slave.sv */
// avalon-mm waitrequest handshake for the interrupt controller registers
// assumes a master that holds read or write until waitrequest is seen low
`timescale 1ns/100ps
`default_nettype none

module dlic_avmm_slave (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // request from the master
    input wire logic i_read,
    input wire logic i_write,
    // handshake back
    output logic o_waitrequest,
    output logic o_capture,
    output logic o_accept
);

    dlic_pkg::dlic_bus_state_t state;
    dlic_pkg::dlic_bus_state_t next_state;
    logic req;

    assign req = i_read | i_write;

    // one wait cycle gives read data a full cycle to settle in its flop
    always_comb begin
        next_state = state;
        case (state)
            dlic_pkg::dlic_bus_idle: begin
                if (req) begin
                    next_state = dlic_pkg::dlic_bus_ack;
                end
            end
            dlic_pkg::dlic_bus_ack: begin
                next_state = dlic_pkg::dlic_bus_idle;
            end
            default: begin
                next_state = dlic_pkg::dlic_bus_idle;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= dlic_pkg::dlic_bus_idle;
        end else begin
            state <= next_state;
        end
    end

    // handshake outputs are combinational
    assign o_waitrequest = req & (state != dlic_pkg::dlic_bus_ack);
    assign o_capture = i_read & (state == dlic_pkg::dlic_bus_idle);
    assign o_accept = req & (state == dlic_pkg::dlic_bus_ack);

endmodule

`default_nettype wire

/* File: rtl/dlic_level.sv */
// one interrupt level: raw sources, enable mask and pending status
// assumes set and clear words are already filtered by byte enables
`timescale 1ns/100ps
`default_nettype none
`include "dlic_consts.svh"

module dlic_level (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // sources
    input wire logic [`DLIC_NUM_SRC-1:0] i_src,
    input wire logic i_swi,
    input wire logic i_sum_raw,
    input wire logic i_sum_pend,
    // mask updates
    input wire logic [31:0] i_set,
    input wire logic [31:0] i_clr,
    // state
    output logic [31:0] o_raw,
    output logic [31:0] o_mask,
    output logic [31:0] o_pending,
    output logic o_any_hi
);

    // set wins over clear; only source bits can ever be enabled
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mask <= `DLIC_MASK_RST;
        end else begin
            o_mask <= ((o_mask & ~i_clr) | i_set) & `DLIC_SRC_MASK;
        end
    end

    // raw follows the sources directly, pending is raw gated by mask except the software and sum bits
    always_comb begin
        o_raw = `DLIC_WORD_ZERO;
        o_raw[`DLIC_SRC_HI:`DLIC_SRC_LO] = i_src;
        o_raw[`DLIC_BIT_SWI] = i_swi;
        o_raw[`DLIC_BIT_SUM] = i_sum_raw;
        o_pending = o_raw & o_mask;
        o_pending[`DLIC_BIT_SWI] = i_swi; // software bit is never masked
        o_pending[`DLIC_BIT_SUM] = i_sum_pend;
    end

    // summary of bits above the sum bit, free of any loop through bit 0
    assign o_any_hi = (|(o_raw[31:1] & o_mask[31:1])) | i_swi;

endmodule

`default_nettype wire

/* File: rtl/dlic_top.sv */
// dual level interrupt controller: normal and fast request lines
// assumes level sources synchronous to i_core_clk, held until cleared
// Notes on behaviour
// [RQ1] ten maskable sources, each to normal or fast
// [RQ2] same bit layout in every level register
// [RQ3] normal request is OR of normal pending
// [RQ4] raw bits read-only, follow peripheral source level
// [RQ5] mask write of one enables, zero ignored
// [RQ6] clear register write-only, ones clear mask bits
// [RQ7] pending equals raw AND mask, read-only
// [RQ8] no priority, no vectors; software selects source
// [RQ9] fast level has identical four registers
// [RQ10] fast request ORs fast pending 31..1
// [RQ11] enabling at one level disables the other
// [RQ12] source may be disabled at both levels
// [RQ13] software interrupt bit is never maskable
// [RQ14] config bits drive software interrupt raw bits
// [RQ15] handler should capture pending status first
// [RQ16] source must hold level long enough
// [RQ17] requests ignore processor interrupt disable bits
// [RQ18] masks and config are zero after reset
`timescale 1ns/100ps
`default_nettype none
`include "dlic_consts.svh"

module dlic_top (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // avalon-mm slave
    input wire logic [`DLIC_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // peripheral interrupt levels, bit 0 is timer0
    input wire logic [`DLIC_NUM_SRC-1:0] i_src,
    // requests to the processor core
    output logic o_irq,
    output logic o_fiq
);

    logic capture;
    logic accept;
    logic wr_acc;
    dlic_pkg::dlic_word_t wdata;
    dlic_pkg::dlic_word_t n_raw;
    dlic_pkg::dlic_word_t n_mask;
    dlic_pkg::dlic_word_t n_pend;
    dlic_pkg::dlic_word_t f_raw;
    dlic_pkg::dlic_word_t f_mask;
    dlic_pkg::dlic_word_t f_pend;
    dlic_pkg::dlic_word_t n_set;
    dlic_pkg::dlic_word_t n_clr;
    dlic_pkg::dlic_word_t f_set;
    dlic_pkg::dlic_word_t f_clr;
    dlic_pkg::dlic_word_t soft_interrupt_config;
    dlic_pkg::dlic_word_t next_rdata;
    logic n_any_hi;
    logic f_any_hi;
    logic fast_or;
    logic wr_n_mask;
    logic wr_n_clr;
    logic wr_f_mask;
    logic wr_f_clr;
    logic wr_soft_interrupt_config;

    // bus handshake: one wait cycle for every access
    dlic_avmm_slave u_slave (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_read(i_avs_read),
        .i_write(i_avs_write),
        .o_waitrequest(o_avs_waitrequest),
        .o_capture(capture),
        .o_accept(accept)
    );

    // lanes with byteenable low write zero, which the mask and clear registers ignore but the config register stores
    assign wdata = i_avs_writedata & {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
        {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    assign wr_acc = accept & i_avs_write;

    // address decode; writes land only at the edge where waitrequest is low
    assign wr_n_mask = wr_acc & (i_avs_address == `DLIC_OFF_NORM_MASK);
    assign wr_n_clr = wr_acc & (i_avs_address == `DLIC_OFF_NORM_CLR);
    assign wr_f_mask = wr_acc & (i_avs_address == `DLIC_OFF_FAST_MASK);
    assign wr_f_clr = wr_acc & (i_avs_address == `DLIC_OFF_FAST_CLR);
    assign wr_soft_interrupt_config = wr_acc & (i_avs_address == `DLIC_OFF_SOFT_INTERRUPT_CONFIG);

    // ones set, zeros do nothing [RQ5]
    assign n_set = wr_n_mask ? (wdata & `DLIC_SRC_MASK) : `DLIC_WORD_ZERO;
    assign f_set = wr_f_mask ? (wdata & `DLIC_SRC_MASK) : `DLIC_WORD_ZERO;
    // a set at one level is a clear at the other [RQ11]
    assign n_clr = (wr_n_clr ? wdata : `DLIC_WORD_ZERO) | f_set; // [RQ6] [RQ12]
    assign f_clr = (wr_f_clr ? wdata : `DLIC_WORD_ZERO) | n_set; // [RQ6] [RQ12]

    // software interrupt config, only bits 2 and 1 are stored [RQ14] [RQ18]
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            soft_interrupt_config <= `DLIC_SOFT_INTERRUPT_CONFIG_RST;
        end else if (wr_soft_interrupt_config) begin
            soft_interrupt_config <= wdata & `DLIC_SOFT_INTERRUPT_CONFIG_MASK;
        end
    end

    // normal level; its sum bit shows the fast summary but never pends [RQ1] [RQ4]
    dlic_level u_normal (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_src(i_src),
        .i_swi(soft_interrupt_config[`DLIC_SOFT_INTERRUPT_CONFIG_NORM]),
        .i_sum_raw(fast_or),
        .i_sum_pend(1'b0),
        .i_set(n_set),
        .i_clr(n_clr),
        .o_raw(n_raw),
        .o_mask(n_mask),
        .o_pending(n_pend),
        .o_any_hi(n_any_hi)
    );

    // fast level, same structure [RQ9] [RQ13]
    dlic_level u_fast (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_src(i_src),
        .i_swi(soft_interrupt_config[`DLIC_SOFT_INTERRUPT_CONFIG_FAST]),
        .i_sum_raw(fast_or),
        .i_sum_pend(fast_or),
        .i_set(f_set),
        .i_clr(f_clr),
        .o_raw(f_raw),
        .o_mask(f_mask),
        .o_pending(f_pend),
        .o_any_hi(f_any_hi)
    );

    // request lines are plain ORs: no priority and no vector [RQ8]
    // no processor-side disable bits reach here, so requests always go out [RQ17]
    assign fast_or = f_any_hi; // [RQ10]
    assign o_fiq = fast_or; // [RQ10]
    assign o_irq = |n_pend; // [RQ3]

    // read mux; clear registers are write-only and read as zero [RQ2] [RQ7]
    always_comb begin
        case (i_avs_address)
            `DLIC_OFF_NORM_RAW: next_rdata = n_raw;
            `DLIC_OFF_NORM_MASK: next_rdata = n_mask;
            `DLIC_OFF_NORM_PEND: next_rdata = n_pend;
            `DLIC_OFF_FAST_RAW: next_rdata = f_raw;
            `DLIC_OFF_FAST_MASK: next_rdata = f_mask;
            `DLIC_OFF_FAST_PEND: next_rdata = f_pend;
            `DLIC_OFF_SOFT_INTERRUPT_CONFIG: next_rdata = soft_interrupt_config;
            default: next_rdata = `DLIC_WORD_ZERO;
        endcase
    end

    // read data snapshots at the first edge, so a level that drops later
    // is still reported; software sees status one cycle old
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_avs_readdata <= `DLIC_WORD_ZERO;
        end else if (capture) begin
            o_avs_readdata <= next_rdata;
        end
    end

    // checks on the controller's own outputs and state

    dlic_pkg::dlic_word_t past_wdata;
    logic past_n_mask;
    logic past_n_clr;
    logic past_f_mask;
    logic past_soft_interrupt_config;

    // helper copies of the previous cycle's write data and accepted write decodes
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            past_wdata <= `DLIC_WORD_ZERO;
            past_n_mask <= 1'b0;
            past_n_clr <= 1'b0;
            past_f_mask <= 1'b0;
            past_soft_interrupt_config <= 1'b0;
        end else begin
            past_wdata <= wdata;
            past_n_mask <= wr_n_mask;
            past_n_clr <= wr_n_clr;
            past_f_mask <= wr_f_mask;
            past_soft_interrupt_config <= wr_soft_interrupt_config;
        end
    end

    a_irq_or_all: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ3]
        o_irq == (|(n_raw & n_mask) | soft_interrupt_config[`DLIC_SOFT_INTERRUPT_CONFIG_NORM]))
    else $error("normal request differs from OR of enabled raw bits");

    a_fiq_summary: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ10]
        o_fiq == (|f_pend[31:1]) && f_pend[`DLIC_BIT_SUM] == o_fiq && n_raw[`DLIC_BIT_SUM] == o_fiq)
    else $error("fast summary bit or line wrong");

    a_raw_follow: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ4]
        n_raw[`DLIC_SRC_HI:`DLIC_SRC_LO] == i_src && f_raw[`DLIC_SRC_HI:`DLIC_SRC_LO] == i_src
        && n_raw[31:`DLIC_SRC_HI+1] == '0)
    else $error("raw bits do not follow the sources");

    a_mask_set_one: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ5]
        past_n_mask |-> ((n_mask & past_wdata & `DLIC_SRC_MASK) == (past_wdata & `DLIC_SRC_MASK))
        && ((n_mask & ~$past(n_mask)) == (past_wdata & `DLIC_SRC_MASK & ~$past(n_mask))))
    else $error("mask write did not set exactly the written ones");

    a_mask_no_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ5]
        wr_n_mask |=> (($past(n_mask) & ~n_mask) == '0))
    else $error("mask write cleared an enable bit");

    a_clear_ones: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ6]
        past_n_clr |-> ((n_mask & past_wdata) == '0)
        && (n_mask == ($past(n_mask) & ~past_wdata)))
    else $error("clear write did not clear exactly the written ones");

    a_pending_and: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ7]
        n_pend[31:`DLIC_SRC_LO] == (n_raw[31:`DLIC_SRC_LO] & n_mask[31:`DLIC_SRC_LO])
        && f_pend[31:`DLIC_SRC_LO] == (f_raw[31:`DLIC_SRC_LO] & f_mask[31:`DLIC_SRC_LO]))
    else $error("pending is not raw and mask");

    a_level_exclusive: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ11]
        past_f_mask |-> ((n_mask & past_wdata & `DLIC_SRC_MASK) == '0) && ((n_mask & f_mask) == '0))
    else $error("source enabled at both levels");

    a_swi_unmasked: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ13]
        n_mask[`DLIC_BIT_SWI] == 1'b0 && f_mask[`DLIC_BIT_SWI] == 1'b0
        && n_pend[`DLIC_BIT_SWI] == n_raw[`DLIC_BIT_SWI])
    else $error("software bit masked");

    a_swi_config: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // [RQ14]
        past_soft_interrupt_config |-> n_raw[`DLIC_BIT_SWI] == past_wdata[`DLIC_SOFT_INTERRUPT_CONFIG_NORM]
        && f_raw[`DLIC_BIT_SWI] == past_wdata[`DLIC_SOFT_INTERRUPT_CONFIG_FAST])
    else $error("config write did not reach software bit");

    a_reset_clear: assert property (@(posedge i_core_clk) // [RQ18]
        $fell(i_sys_rst) |-> n_mask == '0 && f_mask == '0 && soft_interrupt_config == '0 && !o_irq)
    else $error("state not zero after reset");

    a_wait_bound: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held for more than one cycle");

    c_irq_rise: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) $rose(o_irq));
    c_fiq_rise: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) $rose(o_fiq));
    c_level_move: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        wr_f_mask && ((wdata & n_mask) != '0));
    c_swi_fast: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $rose(soft_interrupt_config[`DLIC_SOFT_INTERRUPT_CONFIG_FAST]));

endmodule

`default_nettype wire

/* File: tb/dlic_periph_model.sv */
// peripheral side model: ten level interrupt sources, each held until cleared
// assumes raise and clear pulses from the bench, synchronous to i_core_clk
`timescale 1ns/100ps
`default_nettype none
`include "dlic_consts.svh"

module dlic_periph_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // peripheral events and clear-register writes
    input wire logic [`DLIC_NUM_SRC-1:0] i_raise,
    input wire logic [`DLIC_NUM_SRC-1:0] i_clear,
    // level outputs to the controller
    output logic [`DLIC_NUM_SRC-1:0] o_src
);
    // level stays up until the peripheral's own clear; a clear in the same cycle as a raise wins
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_src <= 10'h000;
        end else begin
            o_src <= (o_src | i_raise) & ~i_clear;
        end
    end
endmodule
`default_nettype wire

/* File: tb/test_dual_level_interrupt_controller.sv */
// self-checking bench for the dual level interrupt controller
// assumes dlic_top with one wait cycle per avalon transfer and the peripheral model
`timescale 1ns/100ps
`default_nettype none

module test_dual_level_interrupt_controller;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] address = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic waitreq;
    logic [9:0] raise = 10'h000;
    logic [9:0] clear = 10'h000;
    logic [9:0] src;
    logic irq;
    logic fast_request;
    int fail_count = 0;
    int comparisons = 0;

    // byte lanes tied on: only whole words are written here
    dlic_top uut (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_avs_address(address), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_src(src), .o_irq(irq), .o_fiq(fast_request));
    dlic_periph_model periph (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_raise(raise), .i_clear(clear),
        .o_src(src));

    // 250 MHz core clock
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon transfer; waitrequest and read data are taken at the rising edge
    task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        address <= a;
        wdata <= d;
        rd <= ~is_wr;
        wr <= is_wr;
        @(posedge core_clk);
        while (waitreq !== 1'b0) begin
            n++;
            if (n > 50) begin
                chk("bus_timeout", 32'h00000001, 32'h00000000);
                report_and_stop();
            end
            @(posedge core_clk);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk(name, q, e);
    endtask

    // one-cycle raise and clear pulses into the peripheral model
    task automatic pulse_src(input logic [9:0] up, input logic [9:0] dn);
        @(posedge core_clk);
        raise <= up;
        clear <= dn;
        @(posedge core_clk);
        raise <= 10'h000;
        clear <= 10'h000;
    endtask

    // request lines are looked at mid-cycle, after the last register update landed
    task automatic lines(input logic ei, input logic ef);
        @(negedge core_clk);
        chk("irq_line", {31'h00000000, irq}, {31'h00000000, ei});
        chk("fiq_line", {31'h00000000, fast_request}, {31'h00000000, ef});
    endtask

    task automatic t_reset();
        rd_chk("norm_mask", 6'h04, 32'h00000000);
        rd_chk("fast_mask", 6'h14, 32'h00000000);
        rd_chk("soft_interrupt_config", 6'h20, 32'h00000000);
        rd_chk("norm_clr", 6'h08, 32'h00000000);
        lines(1'b0, 1'b0);
        // second reset in mid-run must wipe a programmed mask
        wr_reg(6'h04, 32'h00000008);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk("mask_rerst", 6'h04, 32'h00000000);
        $display("test reset done");
    endtask

    task automatic t_raw_mask();
        pulse_src(10'h041, 10'h000);
        rd_chk("norm_raw", 6'h00, 32'h00000104);
        rd_chk("fast_raw", 6'h10, 32'h00000104);
        wr_reg(6'h00, 32'h00000000);
        rd_chk("raw_ro", 6'h00, 32'h00000104);
        rd_chk("pend_off", 6'h0C, 32'h00000000);
        lines(1'b0, 1'b0);
        wr_reg(6'h04, 32'hFFFFFFFF);
        rd_chk("mask_all", 6'h04, 32'h00000FFC);
        wr_reg(6'h04, 32'h00000000);
        rd_chk("mask_zero", 6'h04, 32'h00000FFC);
        rd_chk("pend_on", 6'h0C, 32'h00000104);
        lines(1'b1, 1'b0);
        wr_reg(6'h08, 32'h00000006);
        rd_chk("mask_clr", 6'h04, 32'h00000FF8);
        rd_chk("pend_clr", 6'h0C, 32'h00000100);
        $display("test raw and mask done");
    endtask

    task automatic t_cross();
        wr_reg(6'h14, 32'h00000104);
        rd_chk("fmask", 6'h14, 32'h00000104);
        rd_chk("nmask_side", 6'h04, 32'h00000EF8);
        rd_chk("fpend", 6'h1C, 32'h00000105);
        rd_chk("nraw_sum", 6'h00, 32'h00000105);
        lines(1'b0, 1'b1);
        wr_reg(6'h04, 32'h00000100);
        rd_chk("fmask_side", 6'h14, 32'h00000004);
        lines(1'b1, 1'b1);
        wr_reg(6'h18, 32'h00000004);
        wr_reg(6'h08, 32'hFFFFFFFF);
        rd_chk("nmask_off", 6'h04, 32'h00000000);
        rd_chk("fmask_off", 6'h14, 32'h00000000);
        lines(1'b0, 1'b0);
        $display("test cross level done");
    endtask

    task automatic t_swi();
        wr_reg(6'h20, 32'h00000002);
        rd_chk("nraw_swi", 6'h00, 32'h00000106);
        rd_chk("npend_swi", 6'h0C, 32'h00000002);
        lines(1'b1, 1'b0);
        wr_reg(6'h20, 32'hFFFFFFFF);
        rd_chk("soft_interrupt_config_rsv", 6'h20, 32'h00000006);
        rd_chk("fpend_swi", 6'h1C, 32'h00000003);
        lines(1'b1, 1'b1);
        wr_reg(6'h20, 32'h00000000);
        lines(1'b0, 1'b0);
        rd_chk("unmapped", 6'h24, 32'h00000000);
        $display("test software interrupt done");
    endtask

    // every source in turn, odd ones routed fast, even ones normal
    task automatic t_all_src();
        pulse_src(10'h000, 10'h3FF);
        for (int i = 0; i < 10; i++) begin
            wr_reg(i[0] ? 6'h14 : 6'h04, 32'h00000004 << i);
            pulse_src(10'h001 << i, 10'h000);
            lines(~i[0], i[0]);
            pulse_src(10'h000, 10'h001 << i);
            lines(1'b0, 1'b0);
            wr_reg(i[0] ? 6'h18 : 6'h08, 32'h00000004 << i);
        end
        $display("test all sources done");
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_raw_mask();
        t_cross();
        t_swi();
        t_all_src();
        report_and_stop();
    end
endmodule
`default_nettype wire
